// ### gcg_pkg.sv
// Purpose: Shared constants and types for the port clock gating and deep-sleep oscillator block
// Assumes: APB with 32-bit data, byte addresses as printed
// Notes: Reserved bits read as zero
package gcg_pkg;
  localparam int GCG_NPORTS = 5;
  localparam logic [11:0] GCG_OFF_RUN = 12'h108;
  localparam logic [11:0] GCG_OFF_SLEEP = 12'h118;
  localparam logic [11:0] GCG_OFF_DEEP = 12'h128;
  localparam logic [11:0] GCG_OFF_OSCCFG = 12'h144;
  localparam logic [11:0] GCG_OFF_RUNCFG = 12'h160;
  localparam logic [11:0] GCG_OFF_IRQ_STATUS = 12'h170;
  localparam logic [11:0] GCG_OFF_IRQ_MASK = 12'h174;
  localparam logic [11:0] GCG_OFF_CLKSTAT = 12'h178;
  localparam int GCG_OSC_SEL_BIT = 0;
  localparam int GCG_ACG_BIT = 0;
  localparam logic [4:0] GCG_GATES_RESET = 5'h00;
  localparam logic GCG_OSC_SEL_RESET = 1'b0;
  localparam logic GCG_ACG_RESET = 1'b0;
  localparam int GCG_IRQ_FAULT = 0;
  localparam int GCG_IRQ_DS_ENTER = 1;
  localparam int GCG_IRQ_DS_EXIT = 2;
  localparam int GCG_NIRQ = 3;

  typedef enum logic [1:0] {
    GCG_PWR_RUN,
    GCG_PWR_SLEEP,
    GCG_PWR_DEEP
  } gcg_pwr_e;

  typedef struct packed {
    logic use_internal_osc;
    logic [3:0] freq_setting;
  } gcg_clk_src_s;

  typedef struct packed {
    logic main_osc_powered;
    logic internal_osc_powered;
    gcg_clk_src_s source;
  } gcg_osc_ctrl_s;
endpackage : gcg_pkg

// ### gcg_port_clock_ctrl.sv
// Purpose: APB register block gating clocks of five GPIO port units and
//   switching the oscillator on deep-sleep entry and exit
// Assumes: Power state, run clock source and port access attempts come from system logic
// Notes: Clock enables are registered levels; the clock tree gates with a latch cell
//
// Operation
// R1 - Each gating register holds five port enables, port A at bit zero, reset zero
// R2 - Enable one clocks the port; zero leaves it unclocked and disabled
// R3 - Access to an unclocked port returns a bus fault
// R4 - Bits 31 to 5 are reserved, read-only
// R5 - Run, sleep and deep-sleep gating copies at 0x108, 0x118, 0x128
// R6 - Register at 0x144 switches system clock to internal oscillator on deep-sleep entry
// R7 - Without the override the main oscillator stays the clock source
// R8 - Override in deep-sleep powers internal oscillator up and main oscillator down
// R9 - Deep-sleep exit restores the source and frequency saved at entry
// R10 - Override bit sits at bit zero, read-write, reset zero
// R11 - Sleep and deep-sleep copies apply only with automatic gating set
// R12 - Enables follow the copy for the current power state, changing glitch-free
//
// Decided for this implementation: the APB interface to the registers.
module gcg_port_clock_ctrl #(
  parameter int NPORTS = gcg_pkg::GCG_NPORTS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power state and run clock source
  input wire gcg_pkg::gcg_pwr_e pwr_state,
  input wire gcg_pkg::gcg_clk_src_s run_clk_src,
  // Port unit access attempts, one bit per port
  input wire logic [NPORTS-1:0] port_access,
  output logic [NPORTS-1:0] port_bus_fault,
  // Port clock enables
  output logic [NPORTS-1:0] port_clk_en,
  // Oscillator control
  output gcg_pkg::gcg_osc_ctrl_s osc_ctrl,
  // Interrupt
  output logic irq
);
  import gcg_pkg::*;

  // Five gate bits per copy are fixed by the register layout
  if (NPORTS != GCG_NPORTS) begin : g_bad_nports
    $error("gcg_port_clock_ctrl: NPORTS must equal GCG_NPORTS");
  end

  typedef struct packed {
    logic [NPORTS-1:0] run_gates;
    logic [NPORTS-1:0] sleep_gates;
    logic [NPORTS-1:0] deep_gates;
    logic osc_sel;
    logic auto_sleep_gating_use;
    logic [GCG_NIRQ-1:0] irq_status;
    logic [GCG_NIRQ-1:0] irq_mask;
    logic [NPORTS-1:0] clk_en;
    logic [NPORTS-1:0] fault;
    logic in_deep;
    gcg_clk_src_s saved_src;
    gcg_osc_ctrl_s osc;
    logic [31:0] rdata;
    logic slverr;
  } gcg_state_s;

  gcg_state_s st;
  gcg_state_s next_st;

  function automatic logic [31:0] zext(input logic [NPORTS-1:0] v);
    zext = '0;
    zext[NPORTS-1:0] = v;
  endfunction : zext

  logic setup;
  logic wr;
  logic entering;
  logic leaving;
  logic [NPORTS-1:0] sel_gates;

  assign setup = psel && !penable;
  // Writes land at the access edge, where pready completes the transfer
  assign wr = psel && penable && pwrite;
  assign entering = (pwr_state == GCG_PWR_DEEP) && !st.in_deep;
  assign leaving = (pwr_state != GCG_PWR_DEEP) && st.in_deep;

  always_comb begin
    sel_gates = st.run_gates; // R11
    if (st.auto_sleep_gating_use) begin
      case (pwr_state)
        GCG_PWR_SLEEP: sel_gates = st.sleep_gates; // R11
        GCG_PWR_DEEP: sel_gates = st.deep_gates; // R11
        default: sel_gates = st.run_gates;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    // Enables are registered so the gate cell sees one clean change per state
    next_st.clk_en = sel_gates; // R12 R2
    next_st.fault = port_access & ~st.clk_en; // R3
    if (wr) begin
      case (paddr)
        GCG_OFF_RUN: next_st.run_gates = pwdata[NPORTS-1:0]; // R5 R4
        GCG_OFF_SLEEP: next_st.sleep_gates = pwdata[NPORTS-1:0]; // R5
        GCG_OFF_DEEP: next_st.deep_gates = pwdata[NPORTS-1:0]; // R5
        GCG_OFF_OSCCFG: next_st.osc_sel = pwdata[GCG_OSC_SEL_BIT]; // R6 R10
        GCG_OFF_RUNCFG: next_st.auto_sleep_gating_use = pwdata[GCG_ACG_BIT];
        GCG_OFF_IRQ_MASK: next_st.irq_mask = pwdata[GCG_NIRQ-1:0];
        GCG_OFF_IRQ_STATUS: next_st.irq_status = st.irq_status & ~pwdata[GCG_NIRQ-1:0];
        default: next_st.irq_status = st.irq_status;
      endcase
    end
    next_st.slverr = 1'b0;
    next_st.rdata = st.rdata;
    if (setup) begin
      next_st.rdata = '0;
      case (paddr)
        GCG_OFF_RUN: next_st.rdata = zext(st.run_gates); // R4
        GCG_OFF_SLEEP: next_st.rdata = zext(st.sleep_gates);
        GCG_OFF_DEEP: next_st.rdata = zext(st.deep_gates);
        GCG_OFF_OSCCFG: next_st.rdata[GCG_OSC_SEL_BIT] = st.osc_sel;
        GCG_OFF_RUNCFG: next_st.rdata[GCG_ACG_BIT] = st.auto_sleep_gating_use;
        GCG_OFF_IRQ_STATUS: next_st.rdata[GCG_NIRQ-1:0] = st.irq_status;
        GCG_OFF_IRQ_MASK: next_st.rdata[GCG_NIRQ-1:0] = st.irq_mask;
        GCG_OFF_CLKSTAT: next_st.rdata = {27'h0, st.osc.source};
        default: next_st.slverr = 1'b1;
      endcase
    end
    // Deep-sleep entry: save the running source, then switch if asked
    if (entering) begin
      next_st.in_deep = 1'b1;
      next_st.saved_src = st.osc.source; // R9
      if (st.osc_sel) begin
        next_st.osc.internal_osc_powered = 1'b1; // R8
        next_st.osc.main_osc_powered = 1'b0; // R8
        next_st.osc.source.use_internal_osc = 1'b1; // R6
      end
    end else if (leaving) begin
      next_st.in_deep = 1'b0;
      next_st.osc.source = st.saved_src; // R9
      next_st.osc.main_osc_powered = 1'b1;
      next_st.osc.internal_osc_powered = st.saved_src.use_internal_osc;
    end else if (!st.in_deep) begin
      next_st.osc.source = run_clk_src; // R7
      next_st.osc.main_osc_powered = 1'b1; // R7
      next_st.osc.internal_osc_powered = run_clk_src.use_internal_osc;
    end
    // Hardware set wins over a software clear in the same cycle
    if (|next_st.fault) begin
      next_st.irq_status[GCG_IRQ_FAULT] = 1'b1;
    end
    if (entering) begin
      next_st.irq_status[GCG_IRQ_DS_ENTER] = 1'b1;
    end
    if (leaving) begin
      next_st.irq_status[GCG_IRQ_DS_EXIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.run_gates <= GCG_GATES_RESET; // R1
      st.sleep_gates <= GCG_GATES_RESET; // R1
      st.deep_gates <= GCG_GATES_RESET; // R1
      st.osc_sel <= GCG_OSC_SEL_RESET; // R10
      st.auto_sleep_gating_use <= GCG_ACG_RESET;
      st.osc.main_osc_powered <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = st.slverr & penable;
  assign port_clk_en = st.clk_en; // R2
  assign port_bus_fault = st.fault; // R3
  assign osc_ctrl = st.osc;
  assign irq = |(st.irq_status & st.irq_mask);
endmodule : gcg_port_clock_ctrl

// ### gcg_port_clock_ctrl_monitor.sv
// Purpose: Port-level checks for the port clock gating controller
// Assumes: One clock domain, bound to the top module
// Notes: Register contents are judged by the bench
module gcg_port_clock_ctrl_monitor
  import gcg_pkg::*;
#(parameter int NPORTS = GCG_NPORTS) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Power state, ports and oscillators
  input wire gcg_pkg::gcg_pwr_e pwr_state,
  input wire gcg_pkg::gcg_clk_src_s run_clk_src,
  input wire logic [NPORTS-1:0] port_access,
  input wire logic [NPORTS-1:0] port_bus_fault,
  input wire logic [NPORTS-1:0] port_clk_en,
  input wire gcg_pkg::gcg_osc_ctrl_s osc_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  AST_FAULT: assert property (port_bus_fault == $past(port_access & ~port_clk_en))
    else $error("bus fault mismatch");
  AST_ENHOLD: assert property ((!psel && $stable(pwr_state)) [*2]
    |=> $stable(port_clk_en)) else $error("enable moved without cause");
  AST_MAIN: assert property ($past(pwr_state) != GCG_PWR_DEEP
    && $past(pwr_state, 2) != GCG_PWR_DEEP |-> osc_ctrl.main_osc_powered) else $error("main off");
  AST_OVR: assert property (osc_ctrl.internal_osc_powered |-> !osc_ctrl.main_osc_powered
    && osc_ctrl.source.use_internal_osc && $past(pwr_state) == GCG_PWR_DEEP) else $error("ovr");
  AST_FOLLOW: assert property ((pwr_state != GCG_PWR_DEEP) [*2]
    |=> osc_ctrl.source == $past(run_clk_src)) else $error("source not restored");
  AST_DEEPHOLD: assert property ((pwr_state == GCG_PWR_DEEP) [*2]
    |=> $stable(osc_ctrl.source)) else $error("source moved in deep-sleep");
endmodule : gcg_port_clock_ctrl_monitor

bind gcg_port_clock_ctrl gcg_port_clock_ctrl_monitor #(.NPORTS(NPORTS)) u_mon (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .pwr_state, .run_clk_src, .port_access, .port_bus_fault,
  .port_clk_en, .osc_ctrl);

// ### tb_gpio_clock_gating_deep_sleep_osc.sv
// Purpose: Self-checking bench for the port clock gating controller
// Assumes: Zero-wait APB slave, 50 ns clock
// Notes: Register rows first, then power-state and interrupt cases
module tb_gpio_clock_gating_deep_sleep_osc;
  timeunit 1ns;
  timeprecision 1ns;
  import gcg_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} gcg_row_s;
  localparam gcg_row_s ROWS [14] = '{'{0, 12'h108, 0, 0}, '{0, 12'h144, 0, 0},
    '{1, 12'h108, 32'hFFFFFFFF, 0}, '{0, 12'h108, 32'h1F, 0}, '{1, 12'h118, 32'hFFFFFFF5, 0},
    '{0, 12'h118, 32'h15, 0}, '{1, 12'h128, 32'hFFFFFFEA, 0}, '{0, 12'h128, 32'h0A, 0},
    '{1, 12'h144, 32'hFFFFFFFF, 0}, '{0, 12'h144, 32'h1, 0}, '{1, 12'h174, 32'h7, 0},
    '{1, 12'h160, 32'h1, 0}, '{1, 12'h000, 32'h5, 1}, '{0, 12'h000, 32'h0, 1}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  gcg_pwr_e pwr_state = GCG_PWR_RUN;
  gcg_clk_src_s run_clk_src = 5'h09;
  logic [4:0] port_access = '0, port_bus_fault, port_clk_en;
  gcg_osc_ctrl_s osc_ctrl;
  int n_errors = 0, num_checks = 0, cyc = 0;
  gcg_port_clock_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pwr_state, .run_clk_src, .port_access, .port_bus_fault, .port_clk_en,
    .osc_ctrl, .irq);
  always #25 pclk = ~pclk;
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    foreach (ROWS[i]) begin
      bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) chk(rd, ROWS[i].d);
      chk(32'(er), 32'(ROWS[i].e));
    end
    chk(32'(port_clk_en), 32'h1F);
    pwr_state <= GCG_PWR_SLEEP;
    repeat (3) @(posedge pclk);
    chk(32'(port_clk_en), 32'h15);
    for (int ov = 0; ov < 2; ov++) begin
      bus(1, GCG_OFF_OSCCFG, 32'(ov));
      pwr_state <= GCG_PWR_DEEP;
      port_access <= 5'h1F;
      repeat (3) @(posedge pclk);
      chk(32'(port_clk_en), 32'h0A);
      chk(32'(port_bus_fault), 32'h15);
      chk(32'(osc_ctrl), ov ? 32'h39 : 32'h49);
      pwr_state <= GCG_PWR_RUN;
      port_access <= 5'h00;
      repeat (3) @(posedge pclk);
      chk(32'(osc_ctrl), 32'h49);
    end
    chk(32'(irq), 32'h1);
    bus(1, GCG_OFF_IRQ_MASK, 0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    bus(0, GCG_OFF_CLKSTAT, 0);
    chk(rd, 32'h09);
    bus(0, GCG_OFF_IRQ_STATUS, 0);
    chk(rd, 32'h7);
    bus(1, GCG_OFF_IRQ_STATUS, 32'h7);
    bus(0, GCG_OFF_IRQ_STATUS, 0);
    chk(rd, 32'h0);
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    chk(32'(port_clk_en), 32'h0);
    chk(32'(osc_ctrl), 32'h40);
    presetn <= 1;
    bus(0, GCG_OFF_RUN, 0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule : tb_gpio_clock_gating_deep_sleep_osc
